// *** rtl/opaddr_consts.svh ***
// constants for the operand addressing block
// assumes inclusion by the design module only
`ifndef OPADDR_CONSTS_SVH
`define OPADDR_CONSTS_SVH
`define REG_PC 4'h0
`define REG_SP 4'h1
`define REG_STATUS 4'h2
`define REG_ZERO 4'h3
`define MODE_REG 2'h0
`define MODE_IDX 2'h1
`define MODE_IND 2'h2
`define MODE_INC 2'h3
`define CONST_4 16'h0004
`define CONST_8 16'h0008
`define CONST_0 16'h0000
`define CONST_1 16'h0001
`define CONST_2 16'h0002
`define CONST_M1 16'hffff
`define WORD_STEP 16'h0002
`define BYTE_STEP 16'h0001
`define PC_RESET 16'h0000
`define BYTE_MASK 16'h00ff
`endif

// *** rtl/opaddr_pkg.sv ***
// types for the operand addressing block
// assumes the constants header sits beside it
package opaddr_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_src_ext,
    st_src_read,
    st_dst_ext,
    st_dst_read,
    st_write,
    st_done
  } addr_state_t;
endpackage : opaddr_pkg

// *** rtl/cpu_operand_addressing.sv ***
// operand addressing, constant generation and extension word fetch
// assumes a memory bus that answers a read in the same cycle as the request
// assumes instruction fields and result inputs stay put while they are in use

`timescale 1ns/1ps
`include "opaddr_consts.svh"
module cpu_operand_addressing
  import opaddr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic op_start,
  input wire logic [3:0] src_reg,
  input wire logic [1:0] src_mode_bits,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode_bit,
  input wire logic byte_op,
  input wire logic [15:0] alu_result,
  input wire logic result_write,
  output logic op_busy,
  output logic op_done,
  output logic [15:0] src_operand,
  output logic [15:0] dst_operand,
  output logic [15:0] dst_address,
  output logic result_is_byte,
  output logic [15:0] pc_value,
  output logic flag_zero,
  output logic flag_negative,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata
);

  // register file: pc, sp, flags word, zero register, twelve general
  logic [15:0] regs [16];
  logic [15:0] next_regs [16];
  // sequencer state, latched fields, resolved operands
  addr_state_t state, next_state;
  logic [15:0] src_operand_q, next_src_operand;
  logic [15:0] dst_operand_q, next_dst_operand;
  logic [15:0] dst_addr_q, next_dst_addr;
  logic [15:0] src_addr_q, next_src_addr;
  logic [3:0] sreg_q, next_sreg;
  logic [1:0] smode_q, next_smode;
  logic [3:0] dreg_q, next_dreg;
  logic dmode_q, next_dmode;
  logic byte_q, next_byte;
  logic zflag_q, next_zflag;
  logic nflag_q, next_nflag;
  // constant generator and write path helpers
  logic [15:0] const_value;
  logic const_hit;
  logic [15:0] step;
  logic [15:0] wr_value;

  // constant generator decode from register and mode
  always_comb begin
    const_hit = 1'b0;
    const_value = `CONST_0;
    if (sreg_q == `REG_ZERO) begin
      const_hit = 1'b1;
      unique case (smode_q)
        `MODE_REG: const_value = `CONST_0;
        `MODE_IDX: const_value = `CONST_1;
        `MODE_IND: const_value = `CONST_2;
        `MODE_INC: const_value = `CONST_M1;
      endcase
    end else if (sreg_q == `REG_STATUS && smode_q[1]) begin
      const_hit = 1'b1;
      const_value = smode_q[0] ? `CONST_8 : `CONST_4;
    end
  end

  // autoincrement step and masked write value
  always_comb begin
    step = byte_q ? `BYTE_STEP : `WORD_STEP;
    wr_value = byte_q ? (alu_result & `BYTE_MASK) : alu_result;
  end

  // addressing sequencer
  always_comb begin
    next_state = state;
    for (int i = 0; i < 16; i++) begin
      next_regs[i] = regs[i];
    end
    next_src_operand = src_operand_q;
    next_dst_operand = dst_operand_q;
    next_dst_addr = dst_addr_q;
    next_src_addr = src_addr_q;
    next_sreg = sreg_q;
    next_smode = smode_q;
    next_dreg = dreg_q;
    next_dmode = dmode_q;
    next_byte = byte_q;
    next_zflag = zflag_q;
    next_nflag = nflag_q;
    unique case (state)
      // latch fields and step past the instruction word
      st_idle: begin
        if (op_start) begin
          next_sreg = src_reg;
          next_smode = src_mode_bits;
          next_dreg = dst_reg;
          next_dmode = dst_mode_bit;
          // status register as a plain register source always makes a word op
          next_byte = byte_op && !(src_reg == `REG_STATUS && src_mode_bits == `MODE_REG);
          // counter moves past the instruction word
          next_regs[`REG_PC] = regs[`REG_PC] + `WORD_STEP;
          next_state = st_src_ext;
        end
      end
      // resolve source: constant, register or address
      st_src_ext: begin
        if (const_hit) begin
          next_src_operand = const_value;
          next_state = st_dst_ext;
        end else begin
          unique case (smode_q)
            `MODE_REG: begin
              next_src_operand = regs[sreg_q];
              next_state = st_dst_ext;
            end
            `MODE_IDX: begin
              // offset word read at pc, base untouched
              next_src_addr = (sreg_q == `REG_STATUS ? `CONST_0 : regs[sreg_q])
                + mem_rdata;
              next_regs[`REG_PC] = regs[`REG_PC] + `WORD_STEP;
              next_state = st_src_read;
            end
            `MODE_IND: begin
              next_src_addr = regs[sreg_q];
              next_state = st_src_read;
            end
            `MODE_INC: begin
              next_src_addr = regs[sreg_q];
              // pc always steps a full word for immediates
              next_regs[sreg_q] = regs[sreg_q] + ((sreg_q == `REG_PC) ? `WORD_STEP : step);
              next_state = st_src_read;
            end
          endcase
        end
      end
      // source operand from memory
      st_src_read: begin
        next_src_operand = byte_q ? (mem_rdata & `BYTE_MASK) : mem_rdata;
        next_state = st_dst_ext;
      end
      // resolve destination: register or indexed address
      st_dst_ext: begin
        if (dmode_q) begin
          next_dst_addr = (dreg_q == `REG_STATUS ? `CONST_0 : regs[dreg_q])
            + mem_rdata;
          next_regs[`REG_PC] = regs[`REG_PC] + `WORD_STEP;
          next_state = st_dst_read;
        end else begin
          next_dst_operand = regs[dreg_q];
          next_state = st_write;
        end
      end
      // destination operand from memory
      st_dst_read: begin
        next_dst_operand = mem_rdata;
        next_state = st_write;
      end
      // result write back and flags
      st_write: begin
        if (result_write) begin
          next_zflag = byte_q ? (wr_value[7:0] == 8'h00) : (wr_value == `CONST_0);
          next_nflag = byte_q ? wr_value[7] : wr_value[15];
          // the zero register accepts no result
          if (!dmode_q && dreg_q != `REG_ZERO) begin
            next_regs[dreg_q] = wr_value;
          end
        end
        next_state = st_done;
      end
      // one-cycle completion
      st_done: begin
        next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  // state registers
  always_ff @(posedge core_clk) begin
    // synchronous clear, counter to its start address
    if (!reset_n) begin
      state <= st_idle;
      for (int i = 0; i < 16; i++) begin
        regs[i] <= (i == 0) ? `PC_RESET : `CONST_0;
      end
      src_operand_q <= `CONST_0;
      dst_operand_q <= `CONST_0;
      dst_addr_q <= `CONST_0;
      src_addr_q <= `CONST_0;
      sreg_q <= 4'h0;
      smode_q <= 2'h0;
      dreg_q <= 4'h0;
      dmode_q <= 1'b0;
      byte_q <= 1'b0;
      zflag_q <= 1'b0;
      nflag_q <= 1'b0;
    end else begin
      // take the computed next values
      state <= next_state;
      for (int i = 0; i < 16; i++) begin
        regs[i] <= next_regs[i];
      end
      src_operand_q <= next_src_operand;
      dst_operand_q <= next_dst_operand;
      dst_addr_q <= next_dst_addr;
      src_addr_q <= next_src_addr;
      sreg_q <= next_sreg;
      smode_q <= next_smode;
      dreg_q <= next_dreg;
      dmode_q <= next_dmode;
      byte_q <= next_byte;
      zflag_q <= next_zflag;
      nflag_q <= next_nflag;
    end
  end

  // memory bus requests per state
  always_comb begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = `CONST_0;
    mem_wdata = `CONST_0;
    unique case (state)
      // source extension word
      st_src_ext: begin
        mem_req = !const_hit && smode_q == `MODE_IDX;
        mem_addr = regs[`REG_PC];
      end
      // source operand read
      st_src_read: begin
        mem_req = 1'b1;
        mem_addr = src_addr_q;
      end
      // destination extension word
      st_dst_ext: begin
        mem_req = dmode_q;
        mem_addr = regs[`REG_PC];
      end
      // destination operand read
      st_dst_read: begin
        mem_req = 1'b1;
        mem_addr = dst_addr_q;
      end
      // result store to memory
      st_write: begin
        mem_req = result_write && dmode_q;
        mem_we = result_write && dmode_q;
        mem_addr = dst_addr_q;
        mem_wdata = byte_q ? (alu_result & `BYTE_MASK) : alu_result;
      end
      default: begin
      end
    endcase
  end

  // outputs
  assign op_busy = (state != st_idle);
  assign op_done = (state == st_done);
  // registered data outputs
  assign src_operand = src_operand_q;
  assign dst_operand = dst_operand_q;
  assign dst_address = dst_addr_q;
  assign result_is_byte = byte_q;
  assign pc_value = regs[`REG_PC];
  assign flag_zero = zflag_q;
  assign flag_negative = nflag_q;

endmodule : cpu_operand_addressing

// *** verification/opaddr_mem_model.sv ***
// memory on the far side of the operand bus
// assumes word index addr[8:1] and a read answered in the request cycle
`timescale 1ns/1ps
module opaddr_mem_model (
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  // fill pattern known to the bench
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = {8'h40, i[7:0]};
    last = 16'h0000;
  end
  // released bus shows inverted last value
  assign mem_rdata = (mem_req && !mem_we) ? mem[mem_addr[8:1]] : ~last;
  // write port and bus history
  always @(posedge core_clk) begin
    last <= mem_rdata;
    if (mem_req && mem_we)
      mem[mem_addr[8:1]] <= mem_wdata;
  end
endmodule : opaddr_mem_model

// *** verification/opaddr_chk_sva.sv ***
// checks on the operand addressing ports
// assumes bind onto the top module
`timescale 1ns/1ps
module opaddr_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic op_start,
  input wire logic [3:0] src_reg,
  input wire logic [1:0] src_mode_bits,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode_bit,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic [15:0] pc_value,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // accepted start and its flavours
  sequence go_s;
    op_start && !op_busy;
  endsequence
  sequence const_s;
    go_s ##0 (!dst_mode_bit && (src_reg == 4'h3 || (src_reg == 4'h2 && src_mode_bits[1])));
  endsequence
  sequence reg_s;
    go_s ##0 (src_mode_bits == 2'h0 && !dst_mode_bit && src_reg != 4'h0 && dst_reg != 4'h0);
  endsequence
  sequence idx_s;
    go_s ##0 (src_mode_bits == 2'h1 && src_reg != 4'h3);
  endsequence
  a_start_busy: assert property (go_s |=> op_busy)
    else $error("busy did not follow start");
  a_done_bound: assert property (go_s |-> ##[4:6] op_done)
    else $error("done missing");
  a_done_pulse: assert property (op_done |=> !op_done && !op_busy)
    else $error("done not single");
  a_done_busy: assert property (op_done |-> op_busy)
    else $error("done while idle");
  a_req_busy: assert property (mem_req |-> op_busy)
    else $error("bus used while idle");
  a_pc_even: assert property (pc_value[0] == 1'b0)
    else $error("odd counter");
  a_pc_idle: assert property (!op_busy && !op_start |=> $stable(pc_value))
    else $error("counter moved while idle");
  a_const_nomem: assert property (const_s |=> (!mem_req) [*4])
    else $error("memory used for constant");
  a_reg_step: assert property (reg_s |=> pc_value == $past(pc_value) + 16'h0002)
    else $error("register op step wrong");
  a_idx_fetch: assert property (idx_s |=> (mem_req && !mem_we && mem_addr == pc_value)
    ##1 pc_value == $past(pc_value) + 16'h0002)
    else $error("extension fetch wrong");
endmodule : opaddr_chk

// *** verification/tb_cpu_operand_addressing.sv ***
// bench for operand addressing: constants, registers, indexed, autoincrement
// assumes the memory model fill pattern {8'h40, word index}
`timescale 1ns/1ps
module tb_cpu_operand_addressing;
  logic core_clk = 1'b0, reset_n = 1'b0, op_start = 1'b0, dst_mode_bit = 1'b0;
  logic byte_op = 1'b0, result_write = 1'b0;
  logic [3:0] src_reg = 4'h0, dst_reg = 4'h0;
  logic [1:0] src_mode_bits = 2'h0;
  logic [15:0] alu_result = 16'h0000, pc = 16'h0000;
  logic op_busy, op_done, result_is_byte, flag_zero, flag_negative, mem_req, mem_we;
  logic [15:0] src_operand, dst_operand, dst_address, pc_value, mem_addr, mem_wdata, mem_rdata;
  int bad_count = 0, check_count = 0;
  cpu_operand_addressing uut (.core_clk(core_clk), .reset_n(reset_n), .op_start(op_start),
    .src_reg(src_reg), .src_mode_bits(src_mode_bits), .dst_reg(dst_reg),
    .dst_mode_bit(dst_mode_bit), .byte_op(byte_op), .alu_result(alu_result),
    .result_write(result_write), .op_busy(op_busy), .op_done(op_done),
    .src_operand(src_operand), .dst_operand(dst_operand), .dst_address(dst_address),
    .result_is_byte(result_is_byte), .pc_value(pc_value), .flag_zero(flag_zero),
    .flag_negative(flag_negative), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  opaddr_mem_model mem (.core_clk(core_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // bench copy of the fill pattern
  function automatic logic [15:0] mv(input logic [15:0] a);
    return {8'h40, a[8:1]};
  endfunction : mv
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // one operation, bounded wait for done, counter bookkeeping
  task automatic op(input logic [3:0] sr, input logic [1:0] sm, input logic [3:0] dr,
      input logic bo, input logic [15:0] alu, input logic wr, input int ext);
    int n;
    @(negedge core_clk);
    src_reg = sr;
    src_mode_bits = sm;
    dst_reg = dr;
    byte_op = bo;
    alu_result = alu;
    result_write = wr;
    op_start = 1'b1;
    @(negedge core_clk);
    op_start = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      stop_test();
    end else begin
      pc = pc + 16'h0002 + 16'(2 * ext);
    end
  endtask : op
  task automatic t_consts;
    logic [15:0] k [6] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff, 16'h0004, 16'h0008};
    for (int i = 0; i < 6; i++) begin
      op(i < 4 ? 4'h3 : 4'h2, i < 4 ? 2'(i) : 2'(i - 2), 4'h5, 1'b0, 16'h0000, 1'b0, 0);
      chk("const", k[i], src_operand);
    end
    chk("pc", pc, pc_value);
  endtask : t_consts
  task automatic t_regs;
    logic [15:0] x;
    op(4'h3, 2'h0, 4'h4, 1'b0, 16'h1230, 1'b1, 0);
    op(4'h4, 2'h0, 4'h6, 1'b0, 16'h0000, 1'b0, 0);
    chk("r4", 16'h1230, src_operand);
    op(4'h3, 2'h0, 4'h5, 1'b1, 16'h5580, 1'b1, 0);
    chk("neg", 16'h0001, 16'(flag_negative));
    op(4'h5, 2'h0, 4'h6, 1'b0, 16'h0000, 1'b0, 0);
    chk("r5", 16'h0080, src_operand);
    op(4'h4, 2'h0, 4'h3, 1'b0, 16'h5a5a, 1'b1, 0);
    // zero register contents show up as an indexed destination base
    x = mv(pc + 16'h0002);
    dst_mode_bit = 1'b1;
    op(4'h3, 2'h0, 4'h3, 1'b0, 16'h0000, 1'b0, 1);
    dst_mode_bit = 1'b0;
    chk("r3", x, dst_address);
    op(4'h3, 2'h0, 4'h7, 1'b1, 16'h5500, 1'b1, 0);
    chk("zero", 16'h0001, 16'(flag_zero));
    chk("isbyte", 16'h0001, 16'(result_is_byte));
    op(4'h2, 2'h0, 4'h6, 1'b1, 16'h0000, 1'b0, 0);
    chk("srword", 16'h0000, 16'(result_is_byte));
    chk("pc", pc, pc_value);
  endtask : t_regs
  task automatic t_index;
    logic [15:0] x;
    logic [15:0] y;
    x = mv(pc + 16'h0002);
    y = mv(pc + 16'h0004);
    dst_mode_bit = 1'b1;
    op(4'h4, 2'h1, 4'h6, 1'b0, 16'h0000, 1'b0, 2);
    dst_mode_bit = 1'b0;
    chk("idx", mv(16'h1230 + x), src_operand);
    chk("dst", y, dst_address);
    chk("dsto", mv(y), dst_operand);
    x = mv(pc + 16'h0002);
    op(4'h2, 2'h1, 4'h6, 1'b0, 16'h0000, 1'b0, 1);
    chk("abs", mv(x), src_operand);
    // extension word read as target minus counter
    x = mv(pc + 16'h0002);
    y = mv(pc + 16'h0002 + x);
    op(4'h0, 2'h1, 4'h6, 1'b0, 16'h0000, 1'b0, 1);
    chk("sym", y, src_operand);
    x = mv(pc + 16'h0002);
    op(4'h0, 2'h3, 4'h6, 1'b0, 16'h0000, 1'b0, 1);
    chk("imm", x, src_operand);
    op(4'h4, 2'h3, 4'h6, 1'b0, 16'h0000, 1'b0, 0);
    chk("inc", mv(16'h1230), src_operand);
    op(4'h4, 2'h3, 4'h6, 1'b1, 16'h0000, 1'b0, 0);
    chk("incb", mv(16'h1232) & 16'h00ff, src_operand);
    op(4'h4, 2'h0, 4'h6, 1'b0, 16'h0000, 1'b0, 0);
    chk("r4", 16'h1233, src_operand);
    chk("pc", pc, pc_value);
  endtask : t_index
  // result stored through an absolute destination, read back indirectly
  task automatic t_store;
    logic [15:0] a;
    a = mv(pc + 16'h0002);
    dst_mode_bit = 1'b1;
    op(4'h3, 2'h0, 4'h2, 1'b0, 16'hbeef, 1'b1, 1);
    dst_mode_bit = 1'b0;
    chk("sto", a, dst_address);
    op(4'h3, 2'h0, 4'h8, 1'b0, a, 1'b1, 0);
    op(4'h8, 2'h2, 4'h6, 1'b0, 16'h0000, 1'b0, 0);
    chk("load", 16'hbeef, src_operand);
    chk("pc", pc, pc_value);
  endtask : t_store
  // reset, then the scenarios
  initial begin
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    t_consts();
    t_regs();
    t_index();
    t_store();
    stop_test();
  end
endmodule : tb_cpu_operand_addressing
bind cpu_operand_addressing opaddr_chk chk (.core_clk(core_clk), .reset_n(reset_n),
  .op_start(op_start), .src_reg(src_reg), .src_mode_bits(src_mode_bits), .dst_reg(dst_reg),
  .dst_mode_bit(dst_mode_bit), .op_busy(op_busy), .op_done(op_done), .pc_value(pc_value),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr));
